// *** rtl/lrm_defs.svh ***
`ifndef LRM_DEFS_SVH
`define LRM_DEFS_SVH

// Register byte offsets on the serial register port
`define LRM_OFF_LIN_MASK 8'h23
`define LRM_OFF_SELECT 8'h24
`define LRM_OFF_CUR_HIGH 8'h25
`define LRM_OFF_CUR_LOW 8'h26

// Mask register layout
`define LRM_BIT_LIN1_PG_INVALID 7
`define LRM_BIT_LIN1_PG_VALID 6
`define LRM_BIT_LIN1_OC 4
`define LRM_BIT_LIN0_PG_INVALID 3
`define LRM_BIT_LIN0_PG_VALID 2
`define LRM_BIT_LIN0_OC 0
`define LRM_MASK_WRITABLE 8'hdd
`define LRM_MASK_RESET 8'hdd

// Selector and result resets
`define LRM_SELECT_RESET 1'h0
`define LRM_RESULT_RESET 9'h000
`define LRM_RESULT_MSB 8

// Live condition index inside the synchroniser vectors
`define LRM_IDX_LIN0_PG 0
`define LRM_IDX_LIN0_OC 1
`define LRM_IDX_LIN1_PG 2
`define LRM_IDX_LIN1_OC 3

// Result scaling
`define LRM_LSB_MA 20
`define LRM_FULL_SCALE_MA 10220

`endif

// *** rtl/lrm_pkg.sv ***
package lrm_pkg;

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0] mask;
        logic sel;
        logic busy;
        logic start;
        logic [8:0] result;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [3:0] irq;
        logic meter_irq;
        logic [7:0] rdata;
    } lrm_state_type;

endpackage : lrm_pkg

// *** rtl/lrm_regbank.sv ***
`timescale 1ns/10ps
`include "lrm_defs.svh"

// Functional notes
// - Lin1 loss of power-good raises no irq while mask bit 7 is set.
// - Lin1 power-good becoming valid raises no irq while bit 6 is set.
// - Lin1 current-limit detection raises no irq while bit 4 is set.
// - Lin0 loss of power-good raises no irq while mask bit 3 is set.
// - Lin0 power-good becoming valid raises no irq while bit 2 is set.
// - Lin0 current-limit detection raises no irq while bit 0 is set.
// - Lin1 power-good status follows live condition regardless of masks.
// - Lin0 power-good status follows live condition regardless of masks.
// - Both current-limit status bits track live condition regardless of masks.
// - Select bit 0 measures converter 0, 1 measures converter 1; resets 0.
// - Every write to the select register starts a new measurement.
// - Result bit 8 reads as bit 0 of upper result register, rest zero.
// - Lower result register holds result bits 7:0, resets to zero.
// - Result counts 20 mA each, full scale 10.22 A.
// - Completion raises the meter-ready irq only when its mask is 0.
module lrm_regbank
    import lrm_pkg::*;
#(
    // Meter result width; registers and state serve nine bits only
    parameter int RESULT_WIDTH = 9
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register port from the serial interface
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    output logic [7:0] reg_rdata,
    // Live regulator conditions, asynchronous
    input wire logic lin0_pg_live,
    input wire logic lin0_overcurrent_live,
    input wire logic lin1_pg_live,
    input wire logic lin1_overcurrent_live,
    // Synchronised status
    output logic lin0_pg_state,
    output logic lin0_overcurrent_state,
    output logic lin1_pg_state,
    output logic lin1_overcurrent_state,
    // Interrupt events, one-cycle pulses
    output logic lin0_pg_irq_flag,
    output logic lin0_overcurrent_irq_flag,
    output logic lin1_pg_irq_flag,
    output logic lin1_overcurrent_irq_flag,
    output logic meter_ready_irq_flag,
    // Load meter engine
    input wire logic meter_ready_irq_mask,
    input wire logic meter_done,
    input wire logic [RESULT_WIDTH-1:0] meter_value,
    output logic meter_start,
    output logic meter_select
);

    // Scale kept for software; one count is 20 mA
    localparam int LSB_MA = `LRM_LSB_MA;
    localparam int FULL_SCALE_MA = `LRM_FULL_SCALE_MA;

    // Elaboration checks; other values are not served by the logic
    if (LSB_MA * 511 != FULL_SCALE_MA) begin : g_bad_scale
        $error("load meter scale inconsistent");
    end
    if (RESULT_WIDTH != `LRM_RESULT_MSB + 1) begin : g_bad_width
        $error("load meter result must be nine bits");
    end

    lrm_state_type st;
    lrm_state_type next_st;
    logic [3:0] rise;
    logic [3:0] fall;

    // Single clock domain for every check below
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Address match used by both write paths and the read mux
    function automatic logic lrm_hit(input logic [7:0] addr,
                                     input logic [7:0] off);
        lrm_hit = (addr == off);
    endfunction : lrm_hit

    // Read value of the addressed register, unmapped reads zero
    function automatic logic [7:0] lrm_read(input logic [7:0] addr,
                                            input lrm_state_type s);
        lrm_read = 8'h00;
        if (lrm_hit(addr, `LRM_OFF_LIN_MASK)) begin
            lrm_read = s.mask & `LRM_MASK_WRITABLE;
        end else if (lrm_hit(addr, `LRM_OFF_SELECT)) begin
            lrm_read = {7'h00, s.sel};
        end else if (lrm_hit(addr, `LRM_OFF_CUR_HIGH)) begin
            lrm_read = {7'h00, s.result[`LRM_RESULT_MSB]};
        end else if (lrm_hit(addr, `LRM_OFF_CUR_LOW)) begin
            lrm_read = s.result[7:0];
        end
    endfunction : lrm_read

    // Edges of the synchronised live conditions
    assign rise = st.sync2 & ~st.prev;
    assign fall = ~st.sync2 & st.prev;

    // Next-state logic
    always_comb begin
        next_st = st;
        // Second stage alone reads the first stage
        next_st.sync1 = {lin1_overcurrent_live, lin1_pg_live,
                         lin0_overcurrent_live, lin0_pg_live};
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;

        // Masks gate only the events, never the status
        next_st.irq[`LRM_IDX_LIN1_PG] =
            (fall[`LRM_IDX_LIN1_PG] & ~st.mask[`LRM_BIT_LIN1_PG_INVALID])
            | (rise[`LRM_IDX_LIN1_PG]
               & ~st.mask[`LRM_BIT_LIN1_PG_VALID]);
        next_st.irq[`LRM_IDX_LIN1_OC] =
            rise[`LRM_IDX_LIN1_OC] & ~st.mask[`LRM_BIT_LIN1_OC];
        next_st.irq[`LRM_IDX_LIN0_PG] =
            (fall[`LRM_IDX_LIN0_PG] & ~st.mask[`LRM_BIT_LIN0_PG_INVALID])
            | (rise[`LRM_IDX_LIN0_PG]
               & ~st.mask[`LRM_BIT_LIN0_PG_VALID]);
        next_st.irq[`LRM_IDX_LIN0_OC] =
            rise[`LRM_IDX_LIN0_OC] & ~st.mask[`LRM_BIT_LIN0_OC];

        // Mask writes; reserved bits stay zero
        if (reg_write && lrm_hit(reg_addr, `LRM_OFF_LIN_MASK)) begin
            next_st.mask = reg_wdata & `LRM_MASK_WRITABLE;
        end

        // Completion latches the result and pulses ready
        next_st.start = 1'b0;
        next_st.meter_irq = 1'b0;
        if (st.busy && meter_done) begin
            next_st.busy = 1'b0;
            next_st.result = meter_value;
            next_st.meter_irq = ~meter_ready_irq_mask;
        end

        // Any write restarts, even with an unchanged value; a restart
        // drops a completion in the same cycle as it belongs to the old run
        if (reg_write && lrm_hit(reg_addr, `LRM_OFF_SELECT)) begin
            next_st.sel = reg_wdata[0];
            next_st.start = 1'b1;
            next_st.busy = 1'b1;
            next_st.result = st.result;
            next_st.meter_irq = 1'b0;
        end

        // Read data registered, one cycle behind the address
        next_st.rdata = lrm_read(reg_addr, st);
    end

    // State register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st <= '0;
            st.mask <= `LRM_MASK_RESET;
            st.sel <= `LRM_SELECT_RESET;
            st.result <= `LRM_RESULT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    assign reg_rdata = st.rdata;
    assign lin0_pg_state = st.sync2[`LRM_IDX_LIN0_PG];
    assign lin0_overcurrent_state = st.sync2[`LRM_IDX_LIN0_OC];
    assign lin1_pg_state = st.sync2[`LRM_IDX_LIN1_PG];
    assign lin1_overcurrent_state = st.sync2[`LRM_IDX_LIN1_OC];
    assign lin0_pg_irq_flag = st.irq[`LRM_IDX_LIN0_PG];
    assign lin0_overcurrent_irq_flag = st.irq[`LRM_IDX_LIN0_OC];
    assign lin1_pg_irq_flag = st.irq[`LRM_IDX_LIN1_PG];
    assign lin1_overcurrent_irq_flag = st.irq[`LRM_IDX_LIN1_OC];
    assign meter_ready_irq_flag = st.meter_irq;
    assign meter_start = st.start;
    assign meter_select = st.sel;

    // Checks on the bank's own behaviour

    a_lin1_fall_masked: assert property (
        fall[`LRM_IDX_LIN1_PG] && st.mask[`LRM_BIT_LIN1_PG_INVALID]
        |=> !lin1_pg_irq_flag)
        else $error("lin1 invalid event passed its mask");

    a_lin1_rise_event: assert property (
        rise[`LRM_IDX_LIN1_PG] && !st.mask[`LRM_BIT_LIN1_PG_VALID]
        |=> lin1_pg_irq_flag)
        else $error("lin1 valid event lost");

    a_lin1_oc_event: assert property (
        $rose(lin1_overcurrent_state)
        |=> lin1_overcurrent_irq_flag == !$past(st.mask[`LRM_BIT_LIN1_OC]))
        else $error("lin1 overcurrent irq wrong");

    a_lin0_fall_event: assert property (
        $fell(lin0_pg_state) && !st.mask[`LRM_BIT_LIN0_PG_INVALID]
        |=> lin0_pg_irq_flag)
        else $error("lin0 invalid event lost");

    a_lin0_rise_masked: assert property (
        rise[`LRM_IDX_LIN0_PG] && st.mask[`LRM_BIT_LIN0_PG_VALID]
        |=> !lin0_pg_irq_flag)
        else $error("lin0 valid event passed its mask");

    a_lin0_oc_cause: assert property (
        lin0_overcurrent_irq_flag
        |-> $past(lin0_overcurrent_state) && !$past(lin0_overcurrent_state, 2))
        else $error("lin0 overcurrent irq without edge");

    a_status_follows: assert property (
        ##3 lin1_overcurrent_state == $past(lin1_overcurrent_live, 2))
        else $error("overcurrent status not tracking");

    a_write_starts: assert property (
        reg_write && reg_addr == `LRM_OFF_SELECT
        |=> meter_start && meter_select == $past(reg_wdata[0]))
        else $error("select write did not start a measurement");

    a_result_holds: assert property (
        !(st.busy && meter_done) |=> $stable(st.result))
        else $error("result changed without completion");

    a_ready_masked: assert property (
        meter_ready_irq_flag |-> $past(!meter_ready_irq_mask && meter_done))
        else $error("meter ready irq not allowed");

    a_reserved_zero: assert property (
        (st.mask & ~`LRM_MASK_WRITABLE) == 8'h00)
        else $error("reserved mask bit set");

    a_lin1_fall_event: assert property (
        fall[`LRM_IDX_LIN1_PG] && !st.mask[`LRM_BIT_LIN1_PG_INVALID]
        |=> lin1_pg_irq_flag)
        else $error("lin1 invalid event lost");

    a_lin1_rise_masked: assert property (
        rise[`LRM_IDX_LIN1_PG] && st.mask[`LRM_BIT_LIN1_PG_VALID]
        |=> !lin1_pg_irq_flag)
        else $error("lin1 valid event passed its mask");

    a_lin1_oc_fall: assert property (
        fall[`LRM_IDX_LIN1_OC] |=> !lin1_overcurrent_irq_flag)
        else $error("lin1 overcurrent release raised an irq");

    a_lin0_oc_event: assert property (
        rise[`LRM_IDX_LIN0_OC]
        |=> lin0_overcurrent_irq_flag == !$past(st.mask[`LRM_BIT_LIN0_OC]))
        else $error("lin0 overcurrent irq wrong");

    a_lin1_pg_status: assert property (
        ##3 lin1_pg_state == $past(lin1_pg_live, 2))
        else $error("lin1 power-good status not tracking");

    a_lin0_pg_status: assert property (
        ##3 lin0_pg_state == $past(lin0_pg_live, 2))
        else $error("lin0 power-good status not tracking");

    a_lin0_oc_status: assert property (
        ##3 lin0_overcurrent_state == $past(lin0_overcurrent_live, 2))
        else $error("lin0 overcurrent status not tracking");

    a_select_holds: assert property (
        !(reg_write && reg_addr == `LRM_OFF_SELECT)
        |=> $stable(meter_select))
        else $error("converter select changed without a write");

    a_high_read: assert property (
        reg_addr == `LRM_OFF_CUR_HIGH
        |=> reg_rdata == {7'h00, $past(st.result[`LRM_RESULT_MSB])})
        else $error("upper result register read wrong");

    a_low_read: assert property (
        reg_addr == `LRM_OFF_CUR_LOW |=> reg_rdata == $past(st.result[7:0]))
        else $error("lower result register read wrong");

    a_ready_pulse: assert property (
        st.busy && meter_done && !meter_ready_irq_mask
        && !(reg_write && reg_addr == `LRM_OFF_SELECT)
        |=> meter_ready_irq_flag)
        else $error("unmasked completion raised no ready irq");

    a_done_loads: assert property (
        st.busy && meter_done && !(reg_write && reg_addr == `LRM_OFF_SELECT)
        |=> st.result == $past(meter_value))
        else $error("completion did not load the result");

    a_restart_drops: assert property (
        reg_write && reg_addr == `LRM_OFF_SELECT |=> !meter_ready_irq_flag)
        else $error("rewrite did not drop a pending completion");

    c_measure_done: cover property (
        meter_start ##[1:30] meter_ready_irq_flag);
    c_lin1_pg_irq: cover property (lin1_pg_irq_flag);
    c_oc_irq: cover property (lin0_overcurrent_irq_flag);
    c_read_high: cover property (
        reg_addr == `LRM_OFF_CUR_HIGH ##1 reg_rdata == 8'h01);

endmodule : lrm_regbank

// *** dv/lrm_meter_model.sv ***
`timescale 1ns/10ps

// Stand-in load meter engine: answers the latest start after a fixed delay
module lrm_meter_model #(
    parameter int DLY = 20,
    parameter logic [8:0] V0 = 9'h1ff,
    parameter logic [8:0] V1 = 9'h0a5
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Engine handshake
    input wire logic meter_start,
    input wire logic meter_select,
    output logic meter_done,
    output logic [8:0] meter_value
);
    int cnt;
    logic [8:0] val;

    // A new start restarts the count, as a rewrite does in silicon
    always @(posedge clock) begin
        if (!reset_n) begin
            cnt <= 0;
            meter_done <= 1'b0;
            val <= 9'h000;
        end else begin
            meter_done <= 1'b0;
            if (meter_start) begin
                cnt <= DLY;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
                meter_done <= (cnt == 1);
                val <= meter_select ? V1 : V0;
            end
        end
    end

    // Outside done the value is garbage, so show the inverse
    assign meter_value = meter_done ? val : ~val;
endmodule : lrm_meter_model

// *** dv/regulator_irq_mask_and_load_meter_test.sv ***
`timescale 1ns/10ps
`include "lrm_defs.svh"

module regulator_irq_mask_and_load_meter_test;
    localparam logic [8:0] V0 = 9'h1ff; // Full scale, 511 x 20 mA
    localparam logic [8:0] V1 = 9'h0a5;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] live = 4'h0;
    logic [3:0] state;
    logic [3:0] flag;
    logic ready_mask = 1'b0;
    logic ready_flag, done, start, sel;
    logic [8:0] value;
    int err_count = 0;
    int tests_run = 0;
    // Address, write data, read-back expected
    logic [23:0] rows [6] = '{24'h23ffdd, 24'h232200, 24'h235a58,
        24'h25ff00, 24'h26ff00, 24'h31ff00};
    logic [7:0] masks [4] = '{8'h00, 8'hdd, 8'h88, 8'h44};
    int ib [4] = '{3, 0, 7, 4};
    int vb [4] = '{2, 0, 6, 4};

    always #12.5 clock = ~clock;

    lrm_regbank lrm_regbank_i (.clock(clock), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_rdata(reg_rdata), .lin0_pg_live(live[0]),
        .lin0_overcurrent_live(live[1]), .lin1_pg_live(live[2]),
        .lin1_overcurrent_live(live[3]), .lin0_pg_state(state[0]),
        .lin0_overcurrent_state(state[1]), .lin1_pg_state(state[2]),
        .lin1_overcurrent_state(state[3]), .lin0_pg_irq_flag(flag[0]),
        .lin0_overcurrent_irq_flag(flag[1]), .lin1_pg_irq_flag(flag[2]),
        .lin1_overcurrent_irq_flag(flag[3]),
        .meter_ready_irq_flag(ready_flag), .meter_ready_irq_mask(ready_mask),
        .meter_done(done), .meter_value(value), .meter_start(start),
        .meter_select(sel));

    lrm_meter_model #(.DLY(20), .V0(V0), .V1(V1)) lrm_meter_model_i (
        .clock(clock), .reset_n(reset_n), .meter_start(start),
        .meter_select(sel), .meter_done(done), .meter_value(value));

    task automatic chk(input string name, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, exp);
        @(negedge clock);
        reg_addr = a;
        repeat (2) @(negedge clock);
        chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    // Change one live condition; pulse shows three edges later
    task automatic ev(input int i, input logic v, input logic exp);
        @(negedge clock);
        live[i] = v;
        repeat (3) @(negedge clock);
        chk("state", {15'h0, state[i]}, {15'h0, v});
        chk("irq", {12'h0, flag}, {12'h0, 4'(exp) << i});
        @(negedge clock);
        chk("irq end", {12'h0, flag}, 16'h0000);
    endtask : ev

    // Bounded wait; the engine answers well inside 40 cycles
    task automatic wait_ready(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (40) begin
            @(negedge clock);
            if (ready_flag === 1'b1) seen = 1'b1;
        end
        chk("ready", {15'h0, seen}, {15'h0, exp});
    endtask : wait_ready

    initial begin
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        foreach (rows[r]) begin
            wr(rows[r][23:16], rows[r][15:8]);
            rd(rows[r][23:16], rows[r][7:0]);
        end
        // Each mask pattern against rise and fall of every condition
        foreach (masks[m]) begin
            wr(`LRM_OFF_LIN_MASK, masks[m]);
            for (int i = 0; i < 4; i++) begin
                ev(i, 1'b1, !masks[m][vb[i]]);
                ev(i, 1'b0, i % 2 == 0 && !masks[m][ib[i]]);
            end
        end
        wr(`LRM_OFF_SELECT, 8'h01);
        chk("start", {15'h0, start}, 16'h0001);
        chk("select", {15'h0, sel}, 16'h0001);
        rd(`LRM_OFF_CUR_HIGH, 8'h00);
        wait_ready(1'b1);
        rd(`LRM_OFF_CUR_LOW, V1[7:0]);
        rd(`LRM_OFF_CUR_HIGH, {7'h00, V1[8]});
        rd(`LRM_OFF_SELECT, 8'h01);
        ready_mask = 1'b1;
        wr(`LRM_OFF_SELECT, 8'h00);
        chk("select", {15'h0, sel}, 16'h0000);
        wait_ready(1'b0);
        rd(`LRM_OFF_CUR_LOW, V0[7:0]);
        rd(`LRM_OFF_CUR_HIGH, {7'h00, V0[8]});
        // Same value again must still start a measurement
        wr(`LRM_OFF_SELECT, 8'h00);
        chk("start", {15'h0, start}, 16'h0001);
        rd(`LRM_OFF_CUR_LOW, V0[7:0]);
        wait_ready(1'b0);
        // Rewrite mid-run: the first run is dropped, the second lands
        ready_mask = 1'b0;
        wr(`LRM_OFF_SELECT, 8'h00);
        repeat (10) @(negedge clock);
        wr(`LRM_OFF_SELECT, 8'h01);
        wait_ready(1'b1);
        rd(`LRM_OFF_CUR_LOW, V1[7:0]);
        // Second reset after the last run has completed
        @(negedge clock);
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        rd(`LRM_OFF_LIN_MASK, 8'hdd);
        rd(`LRM_OFF_CUR_LOW, 8'h00);
        rd(`LRM_OFF_CUR_HIGH, 8'h00);
        rd(`LRM_OFF_SELECT, 8'h00);
        end_of_test();
    end

    // Watchdog; the sequence needs well under 1500 cycles
    initial begin
        repeat (4000) @(posedge clock);
        err_count++;
        end_of_test();
    end
endmodule : regulator_irq_mask_and_load_meter_test
